// ---- rtl/sbc_pkg.sv ----
// Package: constants, types and helpers of the SDRAM bank command logic
// How it works
// [RULE1] Chip select high is a deselect; running operations carry on.
// [RULE2] Chip select low with all strobes high is a no-op.
// [RULE3] An idle bank takes an activate and opens the addressed row.
// [RULE4] Refresh and mode load only come with every bank idle.
// [RULE5] Precharge to an idle bank leaves it idle, a no-op there.
// [RULE6] A row active bank takes a read and starts a read burst.
// [RULE7] A row active bank takes a write and starts a write burst.
// [RULE8] Precharge closes the open row of one bank or all banks.
// [RULE9] Read or write to a bursting bank restarts the burst there.
// [RULE10] Precharge during a plain read burst cuts it and precharges.
// [RULE11] Precharge during a plain write burst cuts it and precharges.
// [RULE12] Burst terminate stops the latest read or write burst, any bank.
// [RULE13] Commands count only with clock enable high now and before; the code lets refresh with clock enable just dropped enter self refresh.
// [RULE14] A precharged bank stays precharging for the row precharge time.
// [RULE15] An activated bank stays activating for the column delay.
// [RULE16] Read with auto precharge holds the bank until precharge ends.
// [RULE17] Write with auto precharge holds the bank until precharge ends.
// [RULE18] No command but burst terminate goes to a bank in a timed transitional state.
// [RULE19] Refresh, mode access and precharge-all accept only no-ops.
// [RULE20] Refresh holds the device for the refresh cycle time.
// [RULE21] Mode load holds the device for the mode register delay.
// [RULE22] Precharge-all precharges every bank for the row precharge time.
// [RULE23] Address bit ten on read or write asks for auto precharge.
// [RULE24] Address bit ten on precharge selects all banks.
// [RULE25] Commands not allowed in a bank state are never issued.
package sbc_pkg;

    localparam int SBC_CLK_MHZ   = 20;
    localparam int SBC_NUM_BANKS = 4;
    localparam int SBC_CW        = 8;

    // Timing figures in ns; plain defaults
    localparam int SBC_TRP_NS  = 20;
    localparam int SBC_ACTIVATE_TO_COLUMN_DELAY_NS = 20;
    localparam int SBC_REFRESH_CYCLE_TIME_NS = 66;
    localparam int SBC_MODE_REGISTER_DELAY_NS = 100;
    localparam int SBC_SELF_REFRESH_EXIT_TIME_NS = 100;

    // Least time rounded up to whole cycles, never below one
    function automatic int sbc_cyc(input int ns);
        int c;
        c = (ns * SBC_CLK_MHZ + 999) / 1000;
        return (c < 1) ? 1 : c;
    endfunction

    localparam logic [SBC_CW-1:0] SBC_TRP_CYC  = SBC_CW'(sbc_cyc(SBC_TRP_NS));
    localparam logic [SBC_CW-1:0] SBC_ACTIVATE_TO_COLUMN_DELAY_CYC = SBC_CW'(sbc_cyc(SBC_ACTIVATE_TO_COLUMN_DELAY_NS));
    localparam logic [SBC_CW-1:0] SBC_REFRESH_CYCLE_TIME_CYC = SBC_CW'(sbc_cyc(SBC_REFRESH_CYCLE_TIME_NS));
    localparam logic [SBC_CW-1:0] SBC_MODE_REGISTER_DELAY_CYC = SBC_CW'(sbc_cyc(SBC_MODE_REGISTER_DELAY_NS));
    localparam logic [SBC_CW-1:0] SBC_SELF_REFRESH_EXIT_TIME_CYC = SBC_CW'(sbc_cyc(SBC_SELF_REFRESH_EXIT_TIME_NS));
    localparam logic [SBC_CW-1:0] SBC_BURST_LEN = 8'h04;
    localparam logic [SBC_CW-1:0] SBC_CNT_RST   = 8'h00;
    localparam logic [SBC_CW-1:0] SBC_ONE       = 8'h01;

    // Strobe codes {row, column, write enable}
    localparam logic [2:0] SBC_CMD_LMR   = 3'h0;
    localparam logic [2:0] SBC_CMD_REF   = 3'h1;
    localparam logic [2:0] SBC_CMD_PRE   = 3'h2;
    localparam logic [2:0] SBC_CMD_ACT   = 3'h3;
    localparam logic [2:0] SBC_CMD_WR    = 3'h4;
    localparam logic [2:0] SBC_CMD_RD    = 3'h5;
    localparam logic [2:0] SBC_CMD_BTERM = 3'h6;
    localparam logic [2:0] SBC_CMD_NOP   = 3'h7;

    typedef enum logic [2:0] {
        SBC_IDLE, SBC_ACTIVATING, SBC_ACTIVE, SBC_READ,
        SBC_WRITE, SBC_READ_AP, SBC_WRITE_AP, SBC_PRECHARGING
    } sbc_bank_e;

    typedef enum logic [2:0] {
        SBC_RUN, SBC_REFRESH, SBC_MODEREG, SBC_PREALL,
        SBC_SELFREF, SBC_EXIT
    } sbc_dev_e;

    typedef struct packed {
        logic       cke;
        logic       cs_n;
        logic       ras_n;
        logic       cas_n;
        logic       we_n;
        logic [1:0] bank_addr;
        logic       auto_precharge_select_bit;
    } sbc_pins_s;

    // Deselected, clock enable high
    localparam sbc_pins_s SBC_PINS_RST = 8'hF8;

    typedef struct packed {
        logic act;
        logic rd;
        logic wr;
        logic pre;
        logic ap;
        logic bterm;
    } sbc_bank_cmd_s;

    typedef struct packed {
        sbc_bank_e         st;
        logic [SBC_CW-1:0] cnt;
    } sbc_bank_s;

    typedef struct packed {
        sbc_pins_s         s1;
        sbc_pins_s         s2;
        logic              cke_prev;
        sbc_dev_e          dev;
        logic [SBC_CW-1:0] cnt;
        logic [1:0]        last_bank;
        logic              taken;
        logic              illegal;
    } sbc_top_s;

endpackage

// ---- rtl/sbc_bank.sv ----
// One bank's state sequencer with its timing counter
`timescale 1ns/100ps
module sbc_bank
    import sbc_pkg::*;
#(
    parameter logic [SBC_CW-1:0] BURST_LEN = SBC_BURST_LEN
) (
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          rst_n,
    // Command from the decoder
    input  wire sbc_bank_cmd_s cmd,
    // Bank state
    output sbc_bank_e          state
);

    sbc_bank_s r;
    sbc_bank_s n;

    always_comb begin
        n = r;
        if (r.cnt != SBC_CNT_RST) begin
            n.cnt = r.cnt - SBC_ONE;
        end
        case (r.st)
            SBC_IDLE: begin
                // A precharge here is dropped [RULE5]
                if (cmd.act) begin
                    n.st  = SBC_ACTIVATING; // [RULE3]
                    n.cnt = SBC_ACTIVATE_TO_COLUMN_DELAY_CYC - SBC_ONE; // [RULE15]
                end
            end
            SBC_ACTIVATING: begin
                if (r.cnt == SBC_CNT_RST) begin
                    n.st = SBC_ACTIVE; // [RULE15]
                end
            end
            SBC_ACTIVE, SBC_READ, SBC_WRITE: begin
                if (r.st != SBC_ACTIVE && r.cnt == SBC_CNT_RST) begin
                    n.st = SBC_ACTIVE;
                end
                if (cmd.bterm) begin
                    n.st = SBC_ACTIVE; // [RULE12]
                end
                if (cmd.rd || cmd.wr) begin // [RULE6] [RULE7] [RULE9]
                    if (cmd.rd) begin
                        n.st = cmd.ap ? SBC_READ_AP : SBC_READ;
                    end else begin
                        n.st = cmd.ap ? SBC_WRITE_AP : SBC_WRITE;
                    end
                    // Auto precharge folds burst and precharge in one span
                    n.cnt = cmd.ap ? BURST_LEN + SBC_TRP_CYC - SBC_ONE
                                   : BURST_LEN - SBC_ONE; // [RULE16] [RULE17]
                end
                if (cmd.pre) begin // [RULE8] [RULE10] [RULE11]
                    n.st  = SBC_PRECHARGING;
                    n.cnt = SBC_TRP_CYC - SBC_ONE; // [RULE14]
                end
            end
            SBC_READ_AP, SBC_WRITE_AP: begin
                if (cmd.bterm) begin
                    n.st  = SBC_PRECHARGING;
                    n.cnt = SBC_TRP_CYC - SBC_ONE;
                end else if (r.cnt == SBC_CNT_RST) begin
                    n.st = SBC_IDLE; // [RULE16] [RULE17]
                end
            end
            SBC_PRECHARGING: begin
                if (r.cnt == SBC_CNT_RST) begin
                    n.st = SBC_IDLE; // [RULE14]
                end
            end
            default: begin
                n.st = SBC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            r.st  <= SBC_IDLE;
            r.cnt <= SBC_CNT_RST;
        end else begin
            r <= n;
        end
    end

    assign state = r.st;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_act_open: assert property ( // [RULE3] [RULE15]
        (r.st == SBC_IDLE && cmd.act) |=>
        (r.st == SBC_ACTIVATING && r.cnt == SBC_ACTIVATE_TO_COLUMN_DELAY_CYC - SBC_ONE))
        else $error("activate did not open the row");

    chk_pre_idle_noop: assert property ( // [RULE5]
        (r.st == SBC_IDLE && cmd.pre && !cmd.act) |=> r.st == SBC_IDLE)
        else $error("precharge changed an idle bank");

    chk_pre_close: assert property ( // [RULE8] [RULE10] [RULE11] [RULE14]
        (r.st inside {SBC_ACTIVE, SBC_READ, SBC_WRITE} && cmd.pre) |=>
        (r.st == SBC_PRECHARGING && r.cnt == SBC_TRP_CYC - SBC_ONE))
        else $error("precharge did not close the row");

    chk_timed_end: assert property ( // [RULE14] [RULE16] [RULE17]
        (r.st inside {SBC_PRECHARGING, SBC_READ_AP, SBC_WRITE_AP}
         && r.cnt == SBC_CNT_RST && !cmd.bterm) |=> r.st == SBC_IDLE)
        else $error("timed state did not end in idle");

    chk_burst_restart: assert property ( // [RULE9]
        (r.st inside {SBC_READ, SBC_WRITE} && cmd.rd && !cmd.ap
         && !cmd.pre) |=> (r.st == SBC_READ
         && r.cnt == BURST_LEN - SBC_ONE))
        else $error("new read did not restart the burst");

endmodule

// ---- rtl/sbc_cmd_fsm.sv ----
// Top: pin capture, command decode and device-wide state of the SDRAM
`timescale 1ns/100ps
module sbc_cmd_fsm
    import sbc_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,

    // Command pins
    input  wire logic       cke,
    input  wire logic       cs_n,
    input  wire logic       ras_n,
    input  wire logic       cas_n,
    input  wire logic       we_n,
    input  wire logic [1:0] bank_addr,
    input  wire logic       auto_precharge_select_bit,

    // Status
    output sbc_bank_e [SBC_NUM_BANKS-1:0] bank_state,
    output sbc_dev_e                      dev_state,
    output logic                          cmd_taken,
    output logic                          cmd_illegal
);

    // ************************************************************
    // Declarations
    // ************************************************************

    sbc_top_s                          r;
    sbc_top_s                          n;
    sbc_pins_s                         pins_in;
    sbc_pins_s                         p;
    sbc_bank_cmd_s [SBC_NUM_BANKS-1:0] bcmd;
    logic [2:0]                        code;
    logic                              live;
    logic                              all_idle;
    logic                              any_busy;
    logic                              tgt_ok;
    sbc_bank_e                         tgt_st;

    // Bank may take this command in this state
    function automatic logic cmd_ok(
        input sbc_bank_e  st,
        input logic [2:0] c
    );
        logic ok;
        ok = 1'b0;
        case (st)
            SBC_IDLE: begin
                ok = (c == SBC_CMD_ACT) || (c == SBC_CMD_PRE);
            end
            SBC_ACTIVE, SBC_READ, SBC_WRITE: begin
                ok = (c == SBC_CMD_RD) || (c == SBC_CMD_WR)
                  || (c == SBC_CMD_PRE);
            end
            default: begin
                ok = 1'b0;
            end
        endcase
        return ok;
    endfunction

    // ************************************************************
    // Pin capture
    // ************************************************************

    assign pins_in = '{
        cke:                       cke,
        cs_n:                      cs_n,
        ras_n:                     ras_n,
        cas_n:                     cas_n,
        we_n:                      we_n,
        bank_addr:                 bank_addr,
        auto_precharge_select_bit: auto_precharge_select_bit
    };

    // Only the second stage is read by logic
    assign p    = r.s2;
    assign code = {p.ras_n, p.cas_n, p.we_n};

    // ************************************************************
    // Decode
    // ************************************************************

    // Deselect blocks execution; clock enable low blocks all but self refresh entry
    assign live = r.cke_prev && p.cke && !p.cs_n
               && (r.dev == SBC_RUN); // [RULE1] [RULE13]

    always_comb begin
        all_idle = 1'b1;
        any_busy = 1'b0;
        for (int i = 0; i < SBC_NUM_BANKS; i++) begin
            if (bank_state[i] != SBC_IDLE) begin
                all_idle = 1'b0;
            end
            if (bank_state[i] inside {SBC_ACTIVATING,
                    SBC_PRECHARGING, SBC_READ_AP, SBC_WRITE_AP}) begin
                any_busy = 1'b1;
            end
        end
    end

    assign tgt_st = bank_state[p.bank_addr];
    assign tgt_ok = cmd_ok(tgt_st, code); // [RULE18] [RULE25]

    always_comb begin
        n         = r;
        n.s1      = pins_in;
        n.s2      = r.s1;
        n.cke_prev = r.s2.cke;
        n.taken   = 1'b0;
        n.illegal = 1'b0;
        bcmd      = '0;
        if (r.cnt != SBC_CNT_RST) begin
            n.cnt = r.cnt - SBC_ONE;
        end

        case (r.dev)
            SBC_RUN: begin
                if (live) begin
                    case (code)
                        SBC_CMD_NOP: begin
                            n.taken = 1'b0; // [RULE2]
                        end
                        SBC_CMD_ACT, SBC_CMD_RD, SBC_CMD_WR: begin
                            if (tgt_ok) begin
                                n.taken = 1'b1;
                                bcmd[p.bank_addr].act =
                                    (code == SBC_CMD_ACT); // [RULE3]
                                bcmd[p.bank_addr].rd =
                                    (code == SBC_CMD_RD); // [RULE6]
                                bcmd[p.bank_addr].wr =
                                    (code == SBC_CMD_WR); // [RULE7]
                                bcmd[p.bank_addr].ap =
                                    p.auto_precharge_select_bit; // [RULE23]
                                if (code != SBC_CMD_ACT) begin
                                    n.last_bank = p.bank_addr;
                                end
                            end else begin
                                n.illegal = 1'b1; // [RULE18]
                            end
                        end
                        SBC_CMD_PRE: begin
                            if (p.auto_precharge_select_bit) begin
                                // Every bank must be fit to precharge
                                if (!any_busy) begin // [RULE22]
                                    n.taken = 1'b1;
                                    n.dev   = SBC_PREALL;
                                    n.cnt   = SBC_TRP_CYC - SBC_ONE;
                                    for (int i = 0; i < SBC_NUM_BANKS;
                                         i++) begin
                                        bcmd[i].pre = 1'b1; // [RULE24]
                                    end
                                end else begin
                                    n.illegal = 1'b1;
                                end
                            end else if (tgt_ok) begin
                                n.taken = 1'b1;
                                bcmd[p.bank_addr].pre = 1'b1; // [RULE8]
                            end else begin
                                n.illegal = 1'b1;
                            end
                        end
                        SBC_CMD_BTERM: begin
                            // Follows the last burst, not the bank pins
                            n.taken = 1'b1;
                            bcmd[r.last_bank].bterm = 1'b1; // [RULE12]
                        end
                        SBC_CMD_REF, SBC_CMD_LMR: begin
                            if (all_idle) begin // [RULE4]
                                n.taken = 1'b1;
                                if (code == SBC_CMD_REF) begin
                                    n.dev = SBC_REFRESH; // [RULE20]
                                    n.cnt = SBC_REFRESH_CYCLE_TIME_CYC - SBC_ONE;
                                end else begin
                                    n.dev = SBC_MODEREG; // [RULE21]
                                    n.cnt = SBC_MODE_REGISTER_DELAY_CYC - SBC_ONE;
                                end
                            end else begin
                                n.illegal = 1'b1;
                            end
                        end
                        default: begin
                            n.illegal = 1'b1;
                        end
                    endcase
                end else if (r.cke_prev && !p.cke && !p.cs_n
                             && code == SBC_CMD_REF && all_idle) begin
                    n.dev   = SBC_SELFREF;
                    n.taken = 1'b1;
                end
            end
            SBC_REFRESH, SBC_MODEREG, SBC_PREALL, SBC_EXIT: begin
                // Commands here are dropped and flagged
                if (!p.cs_n && code != SBC_CMD_NOP) begin
                    n.illegal = 1'b1; // [RULE19]
                end
                if (r.cnt == SBC_CNT_RST) begin
                    n.dev = SBC_RUN; // [RULE20] [RULE21] [RULE22]
                end
            end
            SBC_SELFREF: begin
                if (p.cke) begin
                    n.dev = SBC_EXIT; // [RULE13]
                    n.cnt = SBC_SELF_REFRESH_EXIT_TIME_CYC - SBC_ONE;
                end
            end
            default: begin
                n.dev = SBC_RUN;
            end
        endcase
    end

    // ************************************************************
    // State register
    // ************************************************************

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            r.s1        <= SBC_PINS_RST;
            r.s2        <= SBC_PINS_RST;
            r.cke_prev  <= 1'b1;
            r.dev       <= SBC_RUN;
            r.cnt       <= SBC_CNT_RST;
            r.last_bank <= 2'h0;
            r.taken     <= 1'b0;
            r.illegal   <= 1'b0;
        end else begin
            r <= n;
        end
    end

    assign dev_state   = r.dev;
    assign cmd_taken   = r.taken;
    assign cmd_illegal = r.illegal;

    // ************************************************************
    // Banks
    // ************************************************************

    for (genvar g = 0; g < SBC_NUM_BANKS; g++) begin : g_bank
        sbc_bank #(
            .BURST_LEN (SBC_BURST_LEN)
        ) u_bank (
            .clk   (clk),
            .rst_n (rst_n),
            .cmd   (bcmd[g]),
            .state (bank_state[g])
        );
    end

    // ************************************************************
    // Checks
    // ************************************************************

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_cs_high_ignored: assert property ( // [RULE1]
        (r.s2.cs_n && r.dev == SBC_RUN) |->
        (bcmd == '0) ##1 !cmd_taken && !cmd_illegal)
        else $error("deselect cycle executed a command");

    chk_nop_keeps_run: assert property ( // [RULE2]
        (live && code == SBC_CMD_NOP) |->
        (bcmd == '0) ##1 (dev_state == SBC_RUN && !cmd_taken))
        else $error("no-op disturbed the device");

    chk_cke_gate: assert property ( // [RULE13]
        (!r.cke_prev || !r.s2.cke) |-> (bcmd == '0))
        else $error("command taken with clock enable low");

    chk_refresh_enter: assert property ( // [RULE20]
        (live && code == SBC_CMD_REF && all_idle) |=>
        (dev_state == SBC_REFRESH && r.cnt == SBC_REFRESH_CYCLE_TIME_CYC - SBC_ONE))
        else $error("refresh did not start its wait");

    chk_lmr_enter: assert property ( // [RULE21]
        (live && code == SBC_CMD_LMR && all_idle) |=>
        (dev_state == SBC_MODEREG && r.cnt == SBC_MODE_REGISTER_DELAY_CYC - SBC_ONE))
        else $error("mode load did not start its wait");

    chk_busy_exit: assert property ( // [RULE20] [RULE21] [RULE22]
        (r.dev inside {SBC_REFRESH, SBC_MODEREG, SBC_PREALL}
         && r.cnt == SBC_CNT_RST) |=> dev_state == SBC_RUN)
        else $error("device wait did not end on time");

    chk_busy_quiet: assert property ( // [RULE19]
        (r.dev != SBC_RUN) |-> (bcmd == '0))
        else $error("command passed during a device wait");

    chk_bterm_route: assert property ( // [RULE12]
        (live && code == SBC_CMD_BTERM) |-> bcmd[r.last_bank].bterm)
        else $error("burst stop missed the latest burst bank");

    chk_preall_bcast: assert property ( // [RULE22] [RULE24]
        (live && code == SBC_CMD_PRE && p.auto_precharge_select_bit
         && !any_busy) |-> (bcmd[0].pre && bcmd[1].pre
         && bcmd[2].pre && bcmd[3].pre) ##1 dev_state == SBC_PREALL)
        else $error("precharge-all did not reach every bank");

    cov_refresh: cover property (
        dev_state == SBC_REFRESH ##1 dev_state == SBC_RUN);

    cov_preall: cover property (
        dev_state == SBC_PREALL ##1 dev_state == SBC_RUN);

    cov_selfref_exit: cover property (
        dev_state == SBC_EXIT ##1 dev_state == SBC_RUN);

    cov_bterm: cover property (live && code == SBC_CMD_BTERM
        && bank_state[r.last_bank] == SBC_READ);

endmodule

// ---- bench/sbc_ctl_model.sv ----
// Controller model that drives the command pins of the SDRAM
`timescale 1ns/100ps
module sbc_ctl_model
    import sbc_pkg::*;
(
    // Clock
    input  wire logic clk,
    // Command pins
    output sbc_pins_s pins
);
    initial pins = SBC_PINS_RST;

    // ***************************************************
    // Issue one command for one cycle
    // ***************************************************
    // Callers keep refresh and mode load to all-idle times
    // Callers send nothing to a bank in a timed state
    // Callers give only deselects while the device is busy
    // Clock enable stays high unless a scenario lowers it
    task automatic issue(input logic cs, input logic [2:0] c,
                         input logic [1:0] ba, input logic a10);
        @(negedge clk);
        {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} = {cs, c};
        pins.bank_addr = ba;
        pins.auto_precharge_select_bit = a10;
        @(negedge clk);
        // Deselected lines show flipped values, never a stale command
        pins.cs_n = 1'b1;
        {pins.ras_n, pins.cas_n, pins.we_n} = ~c;
        pins.bank_addr = ~ba;
        pins.auto_precharge_select_bit = ~a10;
    endtask

    // Refresh code with clock enable dropped enters self refresh
    task automatic enter_self_refresh();
        @(negedge clk);
        pins.cke = 1'b0;
        {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} = {1'b0, SBC_CMD_REF};
        @(negedge clk);
        pins.cs_n = 1'b1;
        {pins.ras_n, pins.cas_n, pins.we_n} = ~SBC_CMD_REF;
    endtask
endmodule

// ---- bench/sdram_bank_command_state_machine_tb.sv ----
// Self-checking testbench of the SDRAM bank command state machine
`timescale 1ns/100ps
module sdram_bank_command_state_machine_tb
    import sbc_pkg::*;
;
    logic                          clk = 1'b0;
    logic                          rst_n = 1'b0;
    int                            mismatches = 0;
    int                            comparisons = 0;
    int                            cyc = 0;
    sbc_pins_s                     pins;
    sbc_bank_e [SBC_NUM_BANKS-1:0] bank_state;
    sbc_dev_e                      dev_state;
    logic                          taken;
    logic                          illegal;

    sbc_ctl_model ctl (.clk(clk), .pins(pins));

    sbc_cmd_fsm DUT (
        .clk(clk), .rst_n(rst_n), .cke(pins.cke), .cs_n(pins.cs_n),
        .ras_n(pins.ras_n), .cas_n(pins.cas_n), .we_n(pins.we_n),
        .bank_addr(pins.bank_addr),
        .auto_precharge_select_bit(pins.auto_precharge_select_bit),
        .bank_state(bank_state), .dev_state(dev_state),
        .cmd_taken(taken), .cmd_illegal(illegal)
    );

    initial begin
        forever #25 clk = ~clk;
    end

    // ***************************************************
    // Shared tasks
    // ***************************************************
    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            mismatches++;
            end_of_test();
        end
    end

    task automatic chk(input logic [2:0] got, input logic [2:0] exp,
                       input string m);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: %s", $time, m);
        end
    endtask

    task automatic w(input int n);
        repeat (n) @(negedge clk);
    endtask

    // Result shows two edges after the pins are sampled
    task automatic op(input logic [2:0] c, input logic [1:0] ba,
                      input logic a10);
        ctl.issue(1'b0, c, ba, a10);
        w(2);
    endtask

    // ***************************************************
    // Scenarios
    // ***************************************************
    task automatic t_bursts();
        op(SBC_CMD_ACT, 2'h1, 1'b0);
        chk(bank_state[1], SBC_ACTIVATING, "activating");
        chk({1'b0, taken, illegal}, 3'h2, "activate taken");
        w(2);
        chk(bank_state[1], SBC_ACTIVE, "row open");
        ctl.issue(1'b0, SBC_CMD_RD, 2'h1, 1'b0);
        ctl.issue(1'b0, SBC_CMD_RD, 2'h1, 1'b0);
        w(4);
        chk(bank_state[1], SBC_READ, "burst restart");
        w(4);
        ctl.issue(1'b0, SBC_CMD_WR, 2'h1, 1'b0);
        ctl.issue(1'b0, SBC_CMD_BTERM, 2'h3, 1'b0);
        w(2);
        chk(bank_state[1], SBC_ACTIVE, "terminate");
        op(SBC_CMD_WR, 2'h1, 1'b0);
        chk(bank_state[1], SBC_WRITE, "write");
        op(SBC_CMD_PRE, 2'h1, 1'b0);
        chk(bank_state[1], SBC_PRECHARGING, "write cut");
        w(2);
        chk(bank_state[1], SBC_IDLE, "precharged");
        op(SBC_CMD_ACT, 2'h1, 1'b0);
        w(2);
        ctl.issue(1'b0, SBC_CMD_RD, 2'h1, 1'b0);
        ctl.issue(1'b0, SBC_CMD_PRE, 2'h1, 1'b0);
        w(2);
        chk(bank_state[1], SBC_PRECHARGING, "read cut");
        w(2);
    endtask

    task automatic t_quiet();
        op(SBC_CMD_ACT, 2'h1, 1'b0);
        w(2);
        ctl.issue(1'b1, SBC_CMD_PRE, 2'h1, 1'b0);
        w(2);
        chk({1'b0, taken, illegal}, 3'h0, "deselect taken");
        ctl.issue(1'b0, SBC_CMD_NOP, 2'h1, 1'b0);
        w(2);
        chk(bank_state[1], SBC_ACTIVE, "nop");
        ctl.pins.cke = 1'b0;
        ctl.issue(1'b0, SBC_CMD_PRE, 2'h1, 1'b0);
        w(2);
        chk(bank_state[1], SBC_ACTIVE, "clock enable low");
        ctl.pins.cke = 1'b1;
        w(3);
        op(SBC_CMD_PRE, 2'h1, 1'b0);
        w(2);
    endtask

    task automatic t_auto();
        op(SBC_CMD_ACT, 2'h2, 1'b0);
        w(2);
        op(SBC_CMD_RD, 2'h2, 1'b1);
        chk(bank_state[2], SBC_READ_AP, "read ap");
        w(7);
        chk(bank_state[2], SBC_IDLE, "read ap done");
        op(SBC_CMD_ACT, 2'h2, 1'b0);
        w(2);
        op(SBC_CMD_WR, 2'h2, 1'b1);
        chk(bank_state[2], SBC_WRITE_AP, "write ap");
        w(7);
        chk(bank_state[2], SBC_IDLE, "write ap done");
    endtask

    task automatic t_device();
        op(SBC_CMD_PRE, 2'h3, 1'b0);
        chk({1'b0, taken, illegal}, 3'h2, "idle precharge taken");
        chk(bank_state[3], SBC_IDLE, "idle precharge");
        op(SBC_CMD_ACT, 2'h0, 1'b0);
        w(2);
        op(SBC_CMD_PRE, 2'h3, 1'b1);
        chk(dev_state, SBC_PREALL, "precharge all");
        w(3);
        chk(bank_state[0], SBC_IDLE, "row closed");
        op(SBC_CMD_REF, 2'h0, 1'b0);
        chk(dev_state, SBC_REFRESH, "refresh");
        w(3);
        chk(dev_state, SBC_RUN, "refresh done");
        op(SBC_CMD_LMR, 2'h0, 1'b0);
        chk(dev_state, SBC_MODEREG, "mode load");
        w(3);
        chk(dev_state, SBC_RUN, "mode load done");
    endtask

    task automatic t_selfref();
        ctl.enter_self_refresh();
        w(2);
        chk(dev_state, SBC_SELFREF, "self refresh");
        ctl.pins.cke = 1'b1;
        w(3);
        chk(dev_state, SBC_EXIT, "exit wait");
        w(2);
        chk(dev_state, SBC_RUN, "exit done");
    endtask

    initial begin
        w(20);
        rst_n = 1'b1;
        w(2);
        t_bursts();
        t_quiet();
        t_auto();
        t_device();
        t_selfref();
        end_of_test();
    end
endmodule
